// File: logic/rsq_regs.svh
// Register offsets, field positions, reset values and timing counts of the reset and interrupt sequencer
`ifndef RSQ_REGS_SVH
`define RSQ_REGS_SVH
`define RSQ_OFF_PEND_A 5'h00
`define RSQ_OFF_PEND_B 5'h04
`define RSQ_OFF_PEND_C 5'h08
`define RSQ_OFF_CTRL 5'h0C
`define RSQ_OFF_STAT 5'h10
`define RSQ_CTRL_SHORT_BIT 0
`define RSQ_CTRL_RESET 1'h0
`define RSQ_STAT_POR_BIT 0
`define RSQ_STAT_PIN_BIT 1
`define RSQ_STAT_ILLADDR_BIT 2
`define RSQ_STAT_UV_BIT 3
`define RSQ_STAT_DEBUG_BIT 4
`define RSQ_STAT_STOP_BIT 5
`define RSQ_STAT_BUSCLK_BIT 6
`define RSQ_CAUSE_POR 5'h01
`define RSQ_LONG_CYCLES 4096
`define RSQ_SHORT_CYCLES 32
`define RSQ_LONG_LAST 12'hFFF
`define RSQ_SHORT_LAST 12'h01F
`define RSQ_HOLD_LAST 12'h03F
`define RSQ_VEC_RESET 16'hFFFE
`define RSQ_VEC_DEBUG 16'hFEFE
`define RSQ_VEC_SWI 16'hFFFC
`endif

// File: logic/rsq_pkg.sv
// Types of the reset and interrupt sequencer
package rsq_pkg;
	typedef enum logic [2:0] {
		RS_RUN = 3'h0,
		RS_LONG = 3'h1,
		RS_PIN = 3'h3,
		RS_HOLD = 3'h2,
		RS_EXT = 3'h6,
		RS_STOP = 3'h4,
		RS_RECOV = 3'h5
	} rsq_rst_state_t;
	typedef enum logic [1:0] {
		IS_IDLE = 2'h0,
		IS_STACK = 2'h1,
		IS_VECTOR = 2'h3
	} rsq_int_state_t;
endpackage

// File: logic/rsq_arbiter.sv
// Fixed-priority arbiter over the maskable interrupt sources
`timescale 1ns/1ps
`default_nettype none
module rsq_arbiter #(
	parameter int N = 21
) (
	input wire logic [N:1] req,
	input wire logic [N:1] en,
	output logic any,
	output logic [4:0] idx
);
	function automatic logic [4:0] rsq_pick(input logic [N:1] v);
		logic [4:0] r;
		r = 5'h00;
		for (int i = N; i >= 1; i--) begin
			if (v[i]) begin
				r = 5'(i);
			end
		end
		return r;
	endfunction

	// Lowest source number has highest priority
	always_comb begin
		any = |(req & en);
		idx = rsq_pick(req & en);
	end
endmodule
`default_nettype wire

// File: logic/rsq_top.sv
// Reset sequencer, recovery counter and interrupt arbitration with Avalon-MM status registers
//
// Chosen here: the Avalon-MM interface to the registers and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "rsq_regs.svh"
module rsq_top import rsq_pkg::*; (
	input wire logic clk,
	input wire logic rst,
	input wire logic [4:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	input wire logic power_on_pulse,
	input wire logic undervoltage_detector,
	input wire logic debug_entry_reset,
	input wire logic debug_mode,
	input wire logic rst_pin_n_in,
	output logic rst_pin_n_out_r,
	output logic rst_pin_oe_r,
	output logic core_reset_r,
	output logic bus_clk_en_r,
	output logic watchdog_clk_r,
	input wire logic op_fetch,
	input wire logic addr_unmapped,
	input wire logic insn_done,
	input wire logic i_mask,
	input wire logic swi_exec,
	input wire logic rti_exec,
	input wire logic stop_exec,
	input wire logic break_req,
	input wire logic stack_done,
	input wire logic [21:1] irq_req,
	input wire logic [21:1] irq_en,
	output logic stack_push_r,
	output logic push_pc_minus1_r,
	output logic stack_pop_r,
	output logic set_mask_r,
	output logic vector_valid_r,
	output logic [15:0] vector_addr_r
);
	////////////////////////////////////////////////////////////////////////////////////////////////
	// Declarations
	rsq_rst_state_t rs_r, rs_nxt;
	rsq_int_state_t is_r;
	logic [11:0] cnt_r;
	logic uv_s1_r, uv_s2_r, pin_s1_r, pin_s2_r;
	logic short_sel_r, rec_short_r;
	logic [4:0] cause_r;
	logic wait_r;
	logic [31:0] rd_nxt;
	logic lat_swi_r;
	logic [4:0] lat_idx_r;
	logic hw_any;
	logic [4:0] hw_idx;
	logic ill_addr, trig_long, trig_short, trig_any, wake, take, rec_done;
	logic bus_wr;
	logic [5:0] hold_cyc_r;

	////////////////////////////////////////////////////////////////////////////////////////////////
	// Pin and detector synchronisers
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			uv_s1_r <= 1'h0;
			uv_s2_r <= 1'h0;
			pin_s1_r <= 1'h1;
			pin_s2_r <= 1'h1;
		end else begin
			uv_s1_r <= undervoltage_detector;
			uv_s2_r <= uv_s1_r;
			pin_s1_r <= rst_pin_n_in;
			pin_s2_r <= pin_s1_r;
		end
	end

	////////////////////////////////////////////////////////////////////////////////////////////////
	// Reset sources
	always_comb begin
		ill_addr = op_fetch & addr_unmapped;
		trig_long = power_on_pulse | uv_s2_r;
		trig_short = ill_addr | debug_entry_reset;
		trig_any = trig_long | trig_short;
		wake = hw_any | break_req | ~pin_s2_r;
		rec_done = cnt_r == (rec_short_r ? `RSQ_SHORT_LAST : `RSQ_LONG_LAST);
	end

	always_comb begin
		rs_nxt = rs_r;
		if (trig_long) begin
			rs_nxt = RS_LONG;
		end else if (trig_short) begin
			rs_nxt = RS_PIN;
		end else begin
			case (rs_r)
				RS_RUN: rs_nxt = !pin_s2_r ? RS_EXT : (stop_exec ? RS_STOP : RS_RUN);
				RS_LONG: rs_nxt = (cnt_r == `RSQ_LONG_LAST) ? RS_PIN : RS_LONG;
				RS_PIN: rs_nxt = (cnt_r == `RSQ_SHORT_LAST) ? RS_HOLD : RS_PIN;
				RS_HOLD: rs_nxt = (cnt_r == `RSQ_HOLD_LAST) ? RS_RUN : RS_HOLD;
				RS_EXT: rs_nxt = pin_s2_r ? RS_RUN : RS_EXT;
				RS_STOP: rs_nxt = wake ? RS_RECOV : RS_STOP;
				RS_RECOV: rs_nxt = rec_done ? RS_RUN : RS_RECOV;
				default: rs_nxt = RS_RUN;
			endcase
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			rs_r <= RS_LONG;
			rst_pin_oe_r <= 1'h1;
			rst_pin_n_out_r <= 1'h0;
			core_reset_r <= 1'h1;
			bus_clk_en_r <= 1'h0;
		end else begin
			rs_r <= rs_nxt;
			rst_pin_oe_r <= (rs_nxt == RS_LONG) | (rs_nxt == RS_PIN);
			rst_pin_n_out_r <= 1'h0;
			core_reset_r <= (rs_nxt == RS_LONG) | (rs_nxt == RS_PIN) | (rs_nxt == RS_HOLD) | (rs_nxt == RS_EXT);
			bus_clk_en_r <= !((rs_nxt == RS_LONG) | (rs_nxt == RS_STOP) | (rs_nxt == RS_RECOV));
		end
	end

	// Recovery option sampled at wakeup
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			rec_short_r <= 1'h0;
		end else if (rs_r == RS_STOP && wake) begin
			rec_short_r <= short_sel_r;
		end
	end

	// Cause of the last reset
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			cause_r <= `RSQ_CAUSE_POR;
		end else if (power_on_pulse) begin
			cause_r <= `RSQ_CAUSE_POR;
		end else if (uv_s2_r) begin
			cause_r <= 5'h08;
		end else if (ill_addr) begin
			cause_r <= 5'h04;
		end else if (debug_entry_reset) begin
			cause_r <= 5'h10;
		end else if (rs_r == RS_RUN && !pin_s2_r) begin
			cause_r <= 5'h02;
		end
	end

	////////////////////////////////////////////////////////////////////////////////////////////////
	// Recovery counter
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			cnt_r <= 12'h000;
			watchdog_clk_r <= 1'h0;
		end else begin
			if (trig_any || rs_nxt == RS_STOP) begin
				cnt_r <= 12'h000;
			end else begin
				cnt_r <= cnt_r + 12'h001;
			end
			watchdog_clk_r <= cnt_r == `RSQ_LONG_LAST;
		end
	end

	////////////////////////////////////////////////////////////////////////////////////////////////
	// Interrupt arbitration and entry
	rsq_arbiter #(
		.N(21)
	) u_arb (
		.req(irq_req),
		.en(irq_en),
		.any(hw_any),
		.idx(hw_idx)
	);

	always_comb begin
		take = insn_done && is_r == IS_IDLE && rs_r == RS_RUN && (swi_exec || (hw_any && !i_mask));
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			is_r <= IS_IDLE;
			lat_swi_r <= 1'h0;
			lat_idx_r <= 5'h00;
		end else if (core_reset_r) begin
			is_r <= IS_IDLE;
		end else begin
			case (is_r)
				IS_IDLE: begin
					if (take) begin
						is_r <= IS_STACK;
						lat_swi_r <= swi_exec;
						lat_idx_r <= hw_idx;
					end
				end
				IS_STACK: begin
					if (stack_done) begin
						is_r <= IS_VECTOR;
					end
				end
				IS_VECTOR: begin
					is_r <= IS_IDLE;
				end
				default: begin
					is_r <= IS_IDLE;
				end
			endcase
		end
	end

	// Program counter, accumulator, index low and condition codes only
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			stack_push_r <= 1'h0;
			push_pc_minus1_r <= 1'h0;
			stack_pop_r <= 1'h0;
		end else begin
			stack_push_r <= (is_r == IS_IDLE && take) || (is_r == IS_STACK && !stack_done);
			push_pc_minus1_r <= is_r == IS_IDLE ? (take && !swi_exec) : (is_r == IS_STACK && !stack_done && !lat_swi_r);
			stack_pop_r <= insn_done && rti_exec && rs_r == RS_RUN;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			set_mask_r <= 1'h0;
			vector_valid_r <= 1'h0;
			vector_addr_r <= `RSQ_VEC_RESET;
		end else if ((rs_r == RS_HOLD || rs_r == RS_EXT) && rs_nxt == RS_RUN) begin
			set_mask_r <= 1'h1;
			vector_valid_r <= 1'h1;
			vector_addr_r <= debug_mode ? `RSQ_VEC_DEBUG : `RSQ_VEC_RESET;
		end else if (is_r == IS_STACK && stack_done && !core_reset_r) begin
			set_mask_r <= 1'h1;
			vector_valid_r <= 1'h1;
			vector_addr_r <= lat_swi_r ? `RSQ_VEC_SWI : `RSQ_VEC_SWI - {10'h000, lat_idx_r, 1'h0};
		end else begin
			set_mask_r <= 1'h0;
			vector_valid_r <= 1'h0;
		end
	end

	////////////////////////////////////////////////////////////////////////////////////////////////
	// Avalon-MM slave: one wait cycle, then answer
	always_comb begin
		bus_wr = avs_write && !wait_r;
		case (avs_address)
			`RSQ_OFF_PEND_A: rd_nxt = {24'h000000, irq_req[6:1], 2'h0};
			`RSQ_OFF_PEND_B: rd_nxt = {24'h000000, irq_req[14:7]};
			`RSQ_OFF_PEND_C: rd_nxt = {25'h0000000, irq_req[21:15]};
			`RSQ_OFF_CTRL: rd_nxt = {31'h00000000, short_sel_r};
			`RSQ_OFF_STAT: rd_nxt = {25'h0000000, bus_clk_en_r, rs_r == RS_STOP, cause_r};
			default: rd_nxt = 32'h00000000;
		endcase
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			wait_r <= 1'h1;
			avs_waitrequest <= 1'h1;
			avs_readdata <= 32'h00000000;
		end else begin
			wait_r <= !((avs_read || avs_write) && wait_r);
			avs_waitrequest <= !((avs_read || avs_write) && wait_r);
			if (avs_read && wait_r) begin
				avs_readdata <= rd_nxt;
			end
		end
	end

	// Only the control register accepts writes
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			short_sel_r <= `RSQ_CTRL_RESET;
		end else if (bus_wr && avs_address == `RSQ_OFF_CTRL && avs_byteenable[0]) begin
			short_sel_r <= avs_writedata[`RSQ_CTRL_SHORT_BIT];
		end
	end

	////////////////////////////////////////////////////////////////////////////////////////////////
	// Checks
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	// Cycles spent in the core-only reset phase
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			hold_cyc_r <= 6'h00;
		end else begin
			hold_cyc_r <= (rs_r == RS_HOLD) ? hold_cyc_r + 6'h01 : 6'h00;
		end
	end

	illegal_fetch_a: assert property (ill_addr && !trig_long |=> rs_r == RS_PIN && core_reset_r && rst_pin_oe_r)
		else $error("illegal fetch did not start reset");
	data_read_a: assert property (addr_unmapped && !op_fetch && !trig_long && !debug_entry_reset && rs_r == RS_RUN
		&& pin_s2_r && !stop_exec |=> !core_reset_r)
		else $error("data read caused reset");
	long_count_a: assert property (rs_r == RS_LONG && cnt_r == `RSQ_LONG_LAST && !trig_any |=> rs_r == RS_PIN
		&& rst_pin_oe_r && cnt_r == 12'h000)
		else $error("long reset did not last 4096 cycles");
	release_timing_a: assert property (rs_r == RS_HOLD && !trig_any |=> !rst_pin_oe_r && (hold_cyc_r == 6'h20) == !core_reset_r)
		else $error("internal reset not released after 32 more cycles");
	stop_clear_a: assert property (rs_r == RS_RUN && stop_exec && pin_s2_r && !trig_any |=> rs_r == RS_STOP
		&& cnt_r == 12'h000 && !bus_clk_en_r)
		else $error("stop did not clear counter");
	recovery_end_a: assert property (rs_r == RS_RECOV && !trig_any && cnt_r == (rec_short_r ? 12'h01F : 12'hFFF)
		|=> rs_r == RS_RUN && bus_clk_en_r)
		else $error("stop recovery length wrong");
	ext_counter_a: assert property (rs_r == RS_EXT && !trig_any |=> cnt_r == $past(cnt_r) + 12'h001)
		else $error("pin reset disturbed counter");
	free_run_a: assert property (rs_r == RS_RUN && !stop_exec && !trig_any |=> cnt_r == $past(cnt_r) + 12'h001)
		else $error("counter not free running");
	entry_mask_a: assert property (is_r == IS_STACK && stack_done && !core_reset_r && !(rs_r == RS_HOLD)
		|=> set_mask_r && vector_valid_r && !stack_push_r)
		else $error("entry did not set mask and vector");
	trap_unmasked_a: assert property (take && swi_exec && i_mask && !core_reset_r |=> stack_push_r
		&& !push_pc_minus1_r)
		else $error("software trap blocked or wrong pc");
	hold_latch_a: assert property (is_r == IS_STACK |=> $stable(lat_idx_r) && $stable(lat_swi_r))
		else $error("latched interrupt displaced");
	hw_vector_a: assert property (is_r == IS_STACK && stack_done && !lat_swi_r && !core_reset_r && rs_r == RS_RUN
		|=> vector_addr_r == 16'hFFFC - {10'h000, $past(lat_idx_r), 1'h0})
		else $error("hardware vector wrong");

	long_reset_c: cover property (rs_r == RS_LONG ##1 rs_r == RS_PIN);
	trap_entry_c: cover property (is_r == IS_VECTOR && lat_swi_r);
	stop_wake_c: cover property (rs_r == RS_RECOV ##1 rs_r == RS_RUN);
endmodule
`default_nettype wire

// File: sim/rsq_core_model.sv
// Behavioural processor core that answers stack push requests
`timescale 1ns/1ps
`default_nettype none
module rsq_core_model (
	input wire logic clk,
	input wire logic rst,
	input wire logic stack_push_r,
	input wire logic slow,
	output logic stack_done
);
	logic [3:0] cnt_r;
	////////////////////////////////////////
	// Pushes PC, A, X and CCR but never H; handlers save H themselves
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			cnt_r <= 4'h0;
			stack_done <= 1'b0;
		end else begin
			stack_done <= 1'b0;
			if (!stack_push_r) begin
				cnt_r <= 4'h0;
			end else if (cnt_r == (slow ? 4'h6 : 4'h1)) begin
				stack_done <= 1'b1;
				cnt_r <= 4'hF;
			end else if (cnt_r != 4'hF) begin
				cnt_r <= cnt_r + 4'h1;
			end
		end
	end
endmodule
`default_nettype wire

// File: sim/tb_rsq_top.sv
// Self-checking bench of the reset and interrupt sequencer
`timescale 1ns/1ps
`default_nettype none
`include "rsq_regs.svh"
module tb_rsq_top import rsq_pkg::*;;
	typedef struct {logic [4:0] off; logic [31:0] flg; logic [15:0] vec;} rsq_row_t;
	logic clk, rst, avs_read, avs_write, power_on_pulse, undervoltage_detector, debug_entry_reset;
	logic debug_mode, rst_pin_n_in, rst_pin_n_out_r, rst_pin_oe_r, core_reset_r, bus_clk_en_r;
	logic watchdog_clk_r, op_fetch, addr_unmapped, insn_done, i_mask, swi_exec, rti_exec, stop_exec;
	logic break_req, stack_done, stack_push_r, push_pc_minus1_r, stack_pop_r, set_mask_r;
	logic vector_valid_r, avs_waitrequest, slow;
	logic [4:0] avs_address;
	logic [31:0] avs_writedata, avs_readdata, d;
	logic [3:0] avs_byteenable;
	logic [21:1] irq_req, irq_en;
	logic [15:0] vector_addr_r;
	rsq_row_t rows [1:21];
	int fails, total_checks, c;
	rsq_top rsq_top_inst (.*);
	rsq_core_model rsq_core_model_inst (.*);
	////////////////////////////////////////
	task automatic complete_run();
		$display("checks %0d mismatches %0d", total_checks, fails);
		if (fails == 0 && total_checks > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	task automatic chk32(input string s, input logic [31:0] e, input logic [31:0] v);
		total_checks++;
		if (v !== e) begin
			fails++;
			$display("MISMATCH %s expected %0h seen %0h", s, e, v);
		end
	endtask
	task automatic chkn(input string s, input int e, input int v);
		total_checks++;
		if (v != e) begin
			fails++;
			$display("MISMATCH %s expected %0d seen %0d", s, e, v);
		end
	endtask
	task automatic tmo(input int k, input int lim);
		if (k >= lim) begin
			fails++;
			$display("MISMATCH wait expected %0d seen %0d", lim, k);
			complete_run();
		end
	endtask
	task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] wd);
		int k;
		@(posedge clk);
		avs_address <= a;
		avs_write <= w;
		avs_read <= !w;
		avs_writedata <= wd;
		k = 0;
		do begin
			@(posedge clk);
			k++;
		end while (avs_waitrequest !== 1'b0 && k < 50);
		d = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
		tmo(k, 50);
	endtask
	task automatic pulse_insn();
		@(posedge clk);
		insn_done <= 1'b1;
		@(posedge clk);
		insn_done <= 1'b0;
		swi_exec <= 1'b0;
		rti_exec <= 1'b0;
	endtask
	task automatic wait_vec(input logic [15:0] v);
		int k;
		k = 0;
		while (vector_valid_r !== 1'b1 && k < 100) begin
			@(posedge clk);
			k++;
		end
		tmo(k, 100);
		chk32("vector", v, vector_addr_r);
		chk32("mask_set", 1, set_mask_r);
	endtask
	task automatic entry(input logic [15:0] v, input logic pc1, input logic [21:1] late);
		int k;
		pulse_insn();
		k = 0;
		while (stack_push_r !== 1'b1 && k < 20) begin
			@(posedge clk);
			k++;
		end
		tmo(k, 20);
		chk32("pc_minus1", pc1, push_pc_minus1_r);
		irq_req <= irq_req | late;
		wait_vec(v);
	endtask
	task automatic rst_seq(input int pin_n, input logic [15:0] v, input logic [31:0] cause);
		int k;
		k = 0;
		while (rst_pin_oe_r !== 1'b1 && k < 20) begin
			@(posedge clk);
			k++;
		end
		tmo(k, 20);
		k = 0;
		while (rst_pin_oe_r === 1'b1 && k < 5000) begin
			@(posedge clk);
			k++;
		end
		tmo(k, 5000);
		if (pin_n > 0) chkn("pin_low", pin_n, k);
		k = 0;
		while (core_reset_r === 1'b1 && k < 100) begin
			@(posedge clk);
			k++;
		end
		chkn("core_hold", 32, k);
		wait_vec(v);
		bus(0, `RSQ_OFF_STAT, 0);
		chk32("cause", cause, d & 32'h1F);
	endtask
	task automatic stop_wake(input logic sh, input int n);
		bus(1, `RSQ_OFF_CTRL, {31'h0, sh});
		@(posedge clk);
		stop_exec <= 1'b1;
		@(posedge clk);
		stop_exec <= 1'b0;
		repeat (3) @(posedge clk);
		chk32("bus_clk_off", 0, bus_clk_en_r);
		break_req <= 1'b1;
		c = 0;
		while (bus_clk_en_r !== 1'b1 && c < 5000) begin
			@(posedge clk);
			c++;
		end
		break_req <= 1'b0;
		tmo(c, 5000);
		chk32("recovery", 1, 32'(c >= n && c <= n + 4));
	endtask
	////////////////////////////////////////
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	initial begin
		{rst, rst_pin_n_in, avs_byteenable, irq_en} = {1'b1, 1'b1, 4'hF, 21'h1FFFFF};
		{avs_read, avs_write, power_on_pulse, undervoltage_detector, debug_entry_reset} = 5'h00;
		{debug_mode, op_fetch, addr_unmapped, insn_done, i_mask, swi_exec} = 6'h00;
		{rti_exec, stop_exec, break_req, slow, avs_address, avs_writedata, irq_req} = '0;
		fails = 0;
		total_checks = 0;
		for (int n = 1; n <= 21; n++) begin
			rows[n].off = n <= 6 ? `RSQ_OFF_PEND_A : n <= 14 ? `RSQ_OFF_PEND_B : `RSQ_OFF_PEND_C;
			rows[n].flg = 32'h1 << (n <= 6 ? n + 1 : n <= 14 ? n - 7 : n - 15);
			rows[n].vec = 16'hFFFC - 16'(2 * n);
		end
		repeat (8) @(posedge clk);
		chk32("reset_out", 32'h15, {avs_waitrequest, rst_pin_n_out_r, rst_pin_oe_r, bus_clk_en_r, core_reset_r});
		rst <= 1'b0;
		rst_seq(0, `RSQ_VEC_RESET, 32'h1 << `RSQ_STAT_POR_BIT);
		bus(0, `RSQ_OFF_CTRL, 0);
		chk32("ctrl_reset", 0, d);
		bus(1, `RSQ_OFF_PEND_A, 32'hFF);
		bus(0, `RSQ_OFF_PEND_A, 0);
		chk32("pend_write", 0, d);
		bus(0, 5'h14, 0);
		chk32("unmapped", 0, d);
		$display("test reset_and_bus done");
		for (int n = 1; n <= 21; n++) begin
			@(posedge clk);
			irq_req <= 21'h1 << (n - 1);
			bus(0, rows[n].off, 0);
			chk32("pending", rows[n].flg, d);
			entry(rows[n].vec, 1'b1, 21'h0);
		end
		irq_req <= 21'h2;
		i_mask <= 1'b1;
		pulse_insn();
		repeat (4) @(posedge clk);
		chk32("masked", 0, stack_push_r);
		i_mask <= 1'b0;
		irq_en <= 21'h1FFFFD;
		pulse_insn();
		repeat (4) @(posedge clk);
		chk32("disabled", 0, stack_push_r);
		{i_mask, swi_exec, irq_en} <= {2'h3, 21'h1FFFFF};
		entry(`RSQ_VEC_SWI, 1'b0, 21'h0);
		{i_mask, slow, irq_req} <= {2'h1, 21'h14};
		entry(16'hFFF6, 1'b1, 21'h1);
		irq_req <= 21'h11;
		rti_exec <= 1'b1;
		pulse_insn();
		@(posedge clk);
		chk32("pop", 1, stack_pop_r);
		entry(16'hFFFA, 1'b1, 21'h0);
		{slow, irq_req, addr_unmapped} <= {22'h0, 1'b1};
		$display("test interrupts done");
		@(posedge clk);
		addr_unmapped <= 1'b0;
		repeat (10) @(posedge clk);
		chk32("data_read", 0, rst_pin_oe_r);
		{op_fetch, addr_unmapped} <= 2'h3;
		@(posedge clk);
		{op_fetch, addr_unmapped} <= 2'h0;
		rst_seq(32, `RSQ_VEC_RESET, 32'h1 << `RSQ_STAT_ILLADDR_BIT);
		{debug_mode, debug_entry_reset} <= 2'h3;
		@(posedge clk);
		debug_entry_reset <= 1'b0;
		rst_seq(32, `RSQ_VEC_DEBUG, 32'h1 << `RSQ_STAT_DEBUG_BIT);
		{debug_mode, undervoltage_detector} <= 2'h1;
		@(posedge clk);
		undervoltage_detector <= 1'b0;
		rst_seq(4128, `RSQ_VEC_RESET, 32'h1 << `RSQ_STAT_UV_BIT);
		power_on_pulse <= 1'b1;
		@(posedge clk);
		power_on_pulse <= 1'b0;
		rst_seq(4128, `RSQ_VEC_RESET, 32'h1 << `RSQ_STAT_POR_BIT);
		$display("test resets done");
		stop_wake(1'b1, `RSQ_SHORT_CYCLES);
		stop_wake(1'b0, `RSQ_LONG_CYCLES);
		$display("test stop done");
		c = 0;
		while (watchdog_clk_r !== 1'b1 && c < 5000) begin
			@(posedge clk);
			c++;
		end
		tmo(c, 5000);
		debug_mode <= 1'b1;
		c = 0;
		do begin
			@(posedge clk);
			c++;
			rst_pin_n_in <= !(c >= 100 && c < 110);
		end while (watchdog_clk_r !== 1'b1 && c < 5000);
		chkn("watchdog_period", 4096, c);
		chk32("pin_vector", `RSQ_VEC_DEBUG, vector_addr_r);
		debug_mode <= 1'b0;
		bus(0, `RSQ_OFF_STAT, 0);
		chk32("cause_pin", 32'h1 << `RSQ_STAT_PIN_BIT, d & 32'h1F);
		$display("test watchdog done");
		complete_run();
	end
endmodule
`default_nettype wire
